// ### logic/sase_pkg.sv
// constants and types shared by the alternate status encoder
package sase_pkg;
    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] SASE_ADR_CTRL = 8'h00;
    localparam logic [7:0] SASE_ADR_STATE = 8'h04;
    localparam logic [7:0] SASE_ADR_IRQ_STAT = 8'h08;
    localparam logic [7:0] SASE_ADR_IRQ_MASK = 8'h0C;
    // ==========================================================
    // control field positions and reset value
    localparam int SASE_CTRL_ALT_SEL = 0;
    localparam int SASE_CTRL_SUP_DIS = 1;
    localparam int SASE_CTRL_SIGNED = 2;
    localparam logic [2:0] SASE_CTRL_RST = 3'h0;
    // ==========================================================
    // event bits of the interrupt status and mask registers
    localparam int SASE_IRQ_W = 2;
    localparam int SASE_IRQ_CAPT = 0;
    localparam int SASE_IRQ_EXP = 1;
    localparam logic [1:0] SASE_IRQ_MASK_RST = 2'h0;
    // ==========================================================
    // error source ranks, 1 most urgent, 0 means none
    localparam int SASE_NSRC = 11;
    localparam logic [3:0] SASE_RANK_NONE = 4'h0;
    localparam logic [3:0] SASE_RANK_SPI = 4'h1;
    localparam logic [3:0] SASE_RANK_MISO = 4'h2;
    localparam logic [3:0] SASE_RANK_RESET = 4'h3;
    localparam logic [3:0] SASE_RANK_SUPPLY = 4'h4;
    localparam logic [3:0] SASE_RANK_TEST = 4'h5;
    localparam logic [3:0] SASE_RANK_FMEM = 4'h6;
    localparam logic [3:0] SASE_RANK_URW = 4'h7;
    localparam logic [3:0] SASE_RANK_UPROM = 4'h8;
    localparam logic [3:0] SASE_RANK_TEMP = 4'h9;
    localparam logic [3:0] SASE_RANK_OFFS = 4'hA;
    localparam logic [3:0] SASE_RANK_OSC = 4'hB;
    // ==========================================================
    // status field codes and sensor data error codes
    localparam logic [1:0] SASE_BASIC_ERR = 2'h3;
    localparam logic [1:0] SASE_DET_INFO = 2'h0;
    localparam logic [1:0] SASE_DET_MEM = 2'h1;
    localparam logic [1:0] SASE_DET_MODE = 2'h2;
    localparam logic [1:0] SASE_DET_COMM = 2'h3;
    localparam logic [11:0] SASE_CODE_UNSIGNED = 12'h000;
    localparam logic [11:0] SASE_CODE_SIGNED = 12'h800;
    // ==========================================================
    // content of the sensor data field
    typedef enum logic [1:0] {
        SASE_DM_SENSOR = 2'b00,
        SASE_DM_ERRCODE = 2'b01,
        SASE_DM_ZERO = 2'b11
    } sase_dmode_t;
endpackage

// ### logic/sase_rank_pick.sv
// picks the most urgent active error source
`timescale 1ns/100ps
`default_nettype none
module sase_rank_pick #(
    parameter int N = 11
) (
    input wire logic [N:1] i_src,
    output logic [3:0] o_rank
);
    if (N < 1 || N > 15) begin : g_bad_n
        $error("sase_rank_pick: N must be 1..15");
    end
    // scanning downward lets the lowest active rank overwrite the rest
    always_comb begin
        o_rank = 4'h0;
        for (int k = N; k >= 1; k--) begin
            if (i_src[k]) begin
                o_rank = 4'(k);
            end
        end
    end
endmodule // sase_rank_pick
`default_nettype wire

// ### logic/sase_sticky.sv
// sticky event bits, cleared by writing one, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module sase_sticky #(
    parameter int W = 2
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_q
);
    if (W < 1) begin : g_bad_w
        $error("sase_sticky: W must be at least 1");
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_q <= '0;
        end else begin
            o_q <= (o_q & ~i_clr) | i_set;
        end
    end
endmodule // sase_sticky
`default_nettype wire

// ### logic/sase_top.sv
// alternate status encoder for serial responses, with wishbone registers
`timescale 1ns/100ps
`default_nettype none
// Function
// R01: each sensor data response carries a two-bit detail status naming the error class.
// R02: detail status reflects device state caught at slave select rising edge.
// R03: alternate encoding only while status-format select bit is set, else standard.
// R04: oscillator, offset, temperature errors: basic 11, detail 00, echo, sensor data.
// R05: memory errors: detail 01, zero echo, error code once or more, arming frozen.
// R06: test mode: detail 10, all-zero data, zero echo, arming frozen.
// R07: supply error, suppression clear: zeros until timer expiry, then code; monitor off.
// R08: supply error, suppression set: zeros until timer expiry, no code, arming frozen.
// R09: reset error: detail 10, zero echo, error code, register error response, frozen.
// R10: output line error: basic 11, detail 11, zero echo, code, register error.
// R11: protocol error: detail 11, zero echo, code, register error, arming frozen.
// R12: error code is all zeros for unsigned data, top bit only for signed.
// R13: with several sources active, the lowest rank is encoded.
module sase_top (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // error sources, bit k is the source of rank k
    input wire logic [sase_pkg::SASE_NSRC:1] i_err_src,
    input wire logic i_ss_rise,
    input wire logic i_supply_timer_expired,
    input wire logic [1:0] i_std_basic,
    input wire logic [1:0] i_std_detail,
    // response fields
    output logic [1:0] o_basic_status_field,
    output logic [1:0] o_detail_status_field,
    output logic o_echo_enable,
    output var sase_pkg::sase_dmode_t o_data_mode,
    output logic [11:0] o_err_code,
    output logic o_reg_err_response,
    output logic o_monitor_disable,
    output logic o_arm_freeze,
    output logic o_irq
);
    // ==========================================================
    // register bus
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [2:0] ctrl_reg;
    logic [1:0] mask_reg;
    logic [1:0] irq_q;
    logic [1:0] irq_clr;
    logic [1:0] irq_set;
    logic [3:0] live_rank;
    logic [3:0] cap_rank_reg;
    logic exp_reg;
    logic wr_fire;
    logic alt_sel;
    logic sup_dis;

    // a write lands on the edge where the master samples ack high
    assign wr_fire = i_wb_cyc && i_wb_stb && i_wb_we && ack_reg && i_wb_sel[0];
    assign alt_sel = ctrl_reg[sase_pkg::SASE_CTRL_ALT_SEL];
    assign sup_dis = ctrl_reg[sase_pkg::SASE_CTRL_SUP_DIS];

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= i_wb_cyc && i_wb_stb && !ack_reg;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdat_reg <= 32'h0000_0000;
        end else if (i_wb_cyc && i_wb_stb && !ack_reg) begin
            unique case (i_wb_adr)
                sase_pkg::SASE_ADR_CTRL: rdat_reg <= {29'h0, ctrl_reg};
                sase_pkg::SASE_ADR_STATE: rdat_reg <= {28'h0, cap_rank_reg};
                sase_pkg::SASE_ADR_IRQ_STAT: rdat_reg <= {30'h0, irq_q};
                sase_pkg::SASE_ADR_IRQ_MASK: rdat_reg <= {30'h0, mask_reg};
                default: rdat_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ctrl_reg <= sase_pkg::SASE_CTRL_RST;
        end else if (wr_fire && i_wb_adr == sase_pkg::SASE_ADR_CTRL) begin
            ctrl_reg <= i_wb_dat[2:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            mask_reg <= sase_pkg::SASE_IRQ_MASK_RST;
        end else if (wr_fire && i_wb_adr == sase_pkg::SASE_ADR_IRQ_MASK) begin
            mask_reg <= i_wb_dat[1:0];
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;

    // ==========================================================
    // interrupts
    assign irq_clr = (wr_fire && i_wb_adr == sase_pkg::SASE_ADR_IRQ_STAT) ?
        i_wb_dat[1:0] : 2'h0;
    assign irq_set[sase_pkg::SASE_IRQ_CAPT] = i_ss_rise && live_rank != 4'h0;
    assign irq_set[sase_pkg::SASE_IRQ_EXP] = i_supply_timer_expired && !exp_reg;

    sase_sticky #(
        .W(sase_pkg::SASE_IRQ_W)
    ) u_sticky (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_set(irq_set),
        .i_clr(irq_clr),
        .o_q(irq_q)
    );

    assign o_irq = |(irq_q & mask_reg);

    // ==========================================================
    // source capture
    sase_rank_pick #(
        .N(sase_pkg::SASE_NSRC)
    ) u_pick (
        .i_src(i_err_src),
        .o_rank(live_rank) // [R13]
    );

    // held for the whole next frame, so any error code goes out at least once
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cap_rank_reg <= sase_pkg::SASE_RANK_NONE;
        end else if (i_ss_rise) begin
            cap_rank_reg <= live_rank; // [R02]
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            exp_reg <= 1'b0;
        end else begin
            exp_reg <= i_supply_timer_expired;
        end
    end

    // ==========================================================
    // encoding
    logic [1:0] basic_next;
    logic [1:0] detail_next;
    logic echo_next;
    sase_pkg::sase_dmode_t mode_next;
    logic regerr_next;
    logic mondis_next;
    logic freeze_next;

    always_comb begin
        basic_next = sase_pkg::SASE_BASIC_ERR;
        detail_next = sase_pkg::SASE_DET_COMM;
        echo_next = 1'b0;
        mode_next = sase_pkg::SASE_DM_ERRCODE;
        regerr_next = 1'b0;
        mondis_next = 1'b0;
        freeze_next = 1'b1;
        unique case (cap_rank_reg)
            sase_pkg::SASE_RANK_OSC,
            sase_pkg::SASE_RANK_OFFS,
            sase_pkg::SASE_RANK_TEMP: begin
                detail_next = sase_pkg::SASE_DET_INFO; // [R04]
                echo_next = 1'b1;
                mode_next = sase_pkg::SASE_DM_SENSOR;
                freeze_next = 1'b0;
            end
            sase_pkg::SASE_RANK_UPROM,
            sase_pkg::SASE_RANK_URW,
            sase_pkg::SASE_RANK_FMEM: begin
                detail_next = sase_pkg::SASE_DET_MEM; // [R05]
            end
            sase_pkg::SASE_RANK_TEST: begin
                detail_next = sase_pkg::SASE_DET_MODE; // [R06]
                mode_next = sase_pkg::SASE_DM_ZERO;
            end
            sase_pkg::SASE_RANK_SUPPLY: begin
                detail_next = sase_pkg::SASE_DET_MODE;
                // zeros until expiry; the code follows only when not suppressed
                mode_next = (i_supply_timer_expired && !sup_dis) ?
                    sase_pkg::SASE_DM_ERRCODE : sase_pkg::SASE_DM_ZERO; // [R07] [R08]
                mondis_next = !sup_dis; // [R07]
            end
            sase_pkg::SASE_RANK_RESET: begin
                detail_next = sase_pkg::SASE_DET_MODE; // [R09]
                regerr_next = 1'b1;
            end
            sase_pkg::SASE_RANK_MISO,
            sase_pkg::SASE_RANK_SPI: begin
                detail_next = sase_pkg::SASE_DET_COMM; // [R10] [R11]
                regerr_next = 1'b1;
            end
            default: begin
                // no error, or an unused rank code: normal response
                basic_next = i_std_basic;
                detail_next = i_std_detail;
                echo_next = 1'b1;
                mode_next = sase_pkg::SASE_DM_SENSOR;
                freeze_next = 1'b0;
            end
        endcase
        // the standard map is built elsewhere; only its fields pass here
        if (!alt_sel) begin
            basic_next = i_std_basic; // [R03]
            detail_next = i_std_detail;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_basic_status_field <= 2'h0;
            o_detail_status_field <= 2'h0;
        end else begin
            o_basic_status_field <= basic_next;
            o_detail_status_field <= detail_next; // [R01]
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_echo_enable <= 1'b1;
            o_data_mode <= sase_pkg::SASE_DM_SENSOR;
            o_reg_err_response <= 1'b0;
            o_monitor_disable <= 1'b0;
            o_arm_freeze <= 1'b0;
        end else begin
            o_echo_enable <= echo_next;
            o_data_mode <= mode_next;
            o_reg_err_response <= regerr_next;
            o_monitor_disable <= mondis_next;
            o_arm_freeze <= freeze_next;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_err_code <= sase_pkg::SASE_CODE_UNSIGNED;
        end else begin
            o_err_code <= ctrl_reg[sase_pkg::SASE_CTRL_SIGNED] ?
                sase_pkg::SASE_CODE_SIGNED : sase_pkg::SASE_CODE_UNSIGNED; // [R12]
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    capture_edge_a: assert property ( // [R02]
        i_ss_rise |=> cap_rank_reg == $past(live_rank))
        else $error("capture does not follow slave select edge");

    lowest_rank_a: assert property ( // [R13]
        i_ss_rise && i_err_src[1] |=> cap_rank_reg == 4'h1)
        else $error("protocol error not given priority");

    std_pass_a: assert property ( // [R03]
        !alt_sel |=> o_detail_status_field == $past(i_std_detail)
            && o_basic_status_field == $past(i_std_basic))
        else $error("standard fields not passed");

    info_err_a: assert property ( // [R04]
        alt_sel && cap_rank_reg >= 4'h9 && cap_rank_reg <= 4'hB
        |=> o_basic_status_field == 2'h3 && o_detail_status_field == 2'h0
            && o_echo_enable && !o_arm_freeze)
        else $error("info error encoding wrong");

    mem_err_a: assert property ( // [R05]
        alt_sel && cap_rank_reg >= 4'h6 && cap_rank_reg <= 4'h8
        |=> o_detail_status_field == 2'h1 && !o_echo_enable
            && o_data_mode == sase_pkg::SASE_DM_ERRCODE && o_arm_freeze)
        else $error("memory error encoding wrong");

    test_zero_a: assert property ( // [R06]
        alt_sel && cap_rank_reg == 4'h5
        |=> o_detail_status_field == 2'h2
            && o_data_mode == sase_pkg::SASE_DM_ZERO && !o_echo_enable)
        else $error("test mode encoding wrong");

    supply_code_a: assert property ( // [R07]
        cap_rank_reg == 4'h4 && !sup_dis
        |=> o_monitor_disable && o_arm_freeze
            && (o_data_mode == sase_pkg::SASE_DM_ERRCODE) == $past(i_supply_timer_expired))
        else $error("supply error handling wrong");

    supply_quiet_a: assert property ( // [R08]
        cap_rank_reg == 4'h4 && sup_dis
        |=> o_data_mode == sase_pkg::SASE_DM_ZERO && o_arm_freeze)
        else $error("suppressed supply error sent a code");

    reset_err_a: assert property ( // [R09]
        alt_sel && cap_rank_reg == 4'h3
        |=> o_detail_status_field == 2'h2 && o_reg_err_response && !o_echo_enable)
        else $error("reset error encoding wrong");

    comm_err_a: assert property ( // [R10] [R11] [R01]
        alt_sel && (cap_rank_reg == 4'h1 || cap_rank_reg == 4'h2)
        |=> o_basic_status_field == 2'h3 && o_detail_status_field == 2'h3
            && o_reg_err_response && o_arm_freeze)
        else $error("communication error encoding wrong");

    err_code_a: assert property ( // [R12]
        ##1 o_err_code == ($past(ctrl_reg[sase_pkg::SASE_CTRL_SIGNED]) ? 12'h800 : 12'h000))
        else $error("error code value wrong");

    irq_level_a: assert property (
        irq_set != 2'h0 |=> (irq_q & $past(irq_set)) == $past(irq_set)
            && (o_irq || (mask_reg & $past(irq_set)) == 2'h0))
        else $error("event lost or interrupt level wrong");

    // behaviour outputs follow the captured rank whatever the field format
    reg_normal_a: assert property ( // [R04] [R05]
        cap_rank_reg == 4'h0 || cap_rank_reg >= 4'h4
        |=> !o_reg_err_response)
        else $error("register error response without cause");

    echo_zero_a: assert property ( // [R05] [R06] [R09] [R10] [R11]
        cap_rank_reg >= 4'h1 && cap_rank_reg <= 4'h8
        |=> !o_echo_enable && o_arm_freeze)
        else $error("error response kept echo or free arming");

    normal_resp_a: assert property ( // [R04]
        cap_rank_reg == 4'h0 || cap_rank_reg >= 4'h9
        |=> o_echo_enable && !o_arm_freeze && o_data_mode == sase_pkg::SASE_DM_SENSOR)
        else $error("normal response disturbed");

    monitor_only_a: assert property ( // [R07]
        cap_rank_reg != 4'h4
        |=> !o_monitor_disable)
        else $error("monitor disabled without supply error");

    supply_seen_c: cover property (
        cap_rank_reg == 4'h4 ##1 i_supply_timer_expired ##1 o_data_mode == sase_pkg::SASE_DM_ERRCODE);
    spi_win_c: cover property (i_ss_rise && i_err_src[1] && i_err_src[11]);
    irq_c: cover property (!o_irq ##1 o_irq);
endmodule // sase_top
`default_nettype wire

// ### verif/sase_spi_master_model.sv
// serial bus master model: runs one command frame and ends it with a select release
`timescale 1ns/100ps
`default_nettype none
module sase_spi_master_model #(
    parameter int FRAME_CYC = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    output logic o_busy,
    output logic o_ss_rise
);
    // ==========================================================
    // frame timing
    // clock and data lines are not modelled: the encoder only sees the select edge
    int cnt_reg;
    always_ff @(posedge i_core_clk) begin
        o_ss_rise <= 1'b0;
        if (!i_rst_n) begin
            cnt_reg <= 0;
            o_busy <= 1'b0;
        end else if (i_start && !o_busy) begin
            cnt_reg <= FRAME_CYC;
            o_busy <= 1'b1;
        end else if (o_busy) begin
            cnt_reg <= cnt_reg - 1;
            if (cnt_reg == 1) begin
                o_busy <= 1'b0;
                o_ss_rise <= 1'b1;
            end
        end
    end
endmodule // sase_spi_master_model
`default_nettype wire

// ### verif/sase_top_bench.sv
// self-checking bench for the alternate status encoder
`timescale 1ns/100ps
`default_nettype none
module sase_top_bench;
    typedef struct packed {
        logic [1:0] basic;
        logic [1:0] det;
        logic echo;
        logic [1:0] mode;
        logic [11:0] code;
        logic regerr;
        logic mon;
        logic mon_chk;
        logic freeze;
    } sase_exp_t;
    // ==========================================================
    // signals
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, ack, start = 1'b0, busy, ss_rise;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0, rd_dat;
    logic [11:1] err_src = 11'h000;
    logic expired = 1'b0, echo, regerr, mon, freeze, irq;
    logic [1:0] std_b = 2'h0, std_d = 2'h0, basic, det, d_reg = 2'h0;
    logic [11:0] code;
    logic [2:0] ctrl_sh = 3'h0;
    sase_pkg::sase_dmode_t dmode;
    int n_errors = 0, compares = 0, cyc_cnt = 0;
    logic [31:0] rdq[$];
    sase_exp_t stq[$];
    sase_exp_t em;
    always #2 i_core_clk = ~i_core_clk;
    sase_top uut (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_wb_cyc(wb_cyc),
        .i_wb_stb(wb_stb),
        .i_wb_we(wb_we),
        .i_wb_adr(wb_adr),
        .i_wb_sel(wb_sel),
        .i_wb_dat(wb_dat),
        .o_wb_dat(rd_dat),
        .o_wb_ack(ack),
        .i_err_src(err_src),
        .i_ss_rise(ss_rise),
        .i_supply_timer_expired(expired),
        .i_std_basic(std_b),
        .i_std_detail(std_d),
        .o_basic_status_field(basic),
        .o_detail_status_field(det),
        .o_echo_enable(echo),
        .o_data_mode(dmode),
        .o_err_code(code),
        .o_reg_err_response(regerr),
        .o_monitor_disable(mon),
        .o_arm_freeze(freeze),
        .o_irq(irq)
    );
    sase_spi_master_model master (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_start(start),
        .o_busy(busy),
        .o_ss_rise(ss_rise)
    );
    // ==========================================================
    // checking
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", nm, want, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [3:0] rank_of(input logic [11:1] s);
        rank_of = 4'h0;
        for (int k = 11; k >= 1; k--)
            if (s[k]) rank_of = 4'(k);
    endfunction
    function automatic sase_exp_t expect_of(input logic [3:0] rk, input logic [2:0] c,
        input logic ex, input logic [1:0] sb, input logic [1:0] sd);
        sase_exp_t e;
        e.echo = (rk == 0) || (rk >= 9);
        e.freeze = (rk >= 1) && (rk <= 8);
        e.regerr = (rk >= 1) && (rk <= 3);
        e.mon = (rk == 4) && !c[1];
        e.mon_chk = !((rk == 4) && c[1]);
        e.code = c[2] ? 12'h800 : 12'h000;
        e.mode = e.echo ? 2'b00 : 2'b01;
        if (rk == 5 || (rk == 4 && !(ex && !c[1])))
            e.mode = 2'b11;
        e.det = (rk >= 9) ? 2'h0 : (rk >= 6) ? 2'h1 : (rk >= 3) ? 2'h2 : 2'h3;
        e.basic = 2'h3;
        if (!c[0] || rk == 0) begin
            e.basic = sb;
            e.det = sd;
        end
        return e;
    endfunction
    always @(posedge i_core_clk) begin
        d_reg <= {d_reg[0], ss_rise};
        if (ack === 1'b1 && wb_we === 1'b0 && rdq.size() > 0)
            chk("rdata", rd_dat, rdq.pop_front());
        if (d_reg[1] && stq.size() > 0) begin
            em = stq.pop_front();
            chk("basic", 32'(basic), 32'(em.basic));
            chk("detail", 32'(det), 32'(em.det));
            chk("echo", 32'(echo), 32'(em.echo));
            chk("dmode", 32'(dmode), 32'(em.mode));
            if (em.mode == 2'b01)
                chk("code", 32'(code), 32'(em.code));
            chk("regerr", 32'(regerr), 32'(em.regerr));
            if (em.mon_chk)
                chk("monitor", 32'(mon), 32'(em.mon));
            chk("freeze", 32'(freeze), 32'(em.freeze));
        end
    end
    // a hang counts as a mismatch; the full run needs well under 10000 cycles
    always @(posedge i_core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    // ==========================================================
    // drivers
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [31:0] ex);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= s;
        if (!w) rdq.push_back(ex);
        @(posedge i_core_clk);
        while (ack !== 1'b1) @(posedge i_core_clk);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic set_ctrl(input logic [2:0] c);
        wb(1'b1, sase_pkg::SASE_ADR_CTRL, {29'h0, c}, 4'hF, 32'h0);
        ctrl_sh = c;
        repeat (2) @(posedge i_core_clk);
    endtask
    task automatic frame(input logic [11:1] s, input logic ex);
        logic [1:0] sb;
        logic [1:0] sd;
        sb = 2'($urandom);
        sd = 2'($urandom);
        err_src <= s;
        expired <= ex;
        std_b <= sb;
        std_d <= sd;
        start <= 1'b1;
        stq.push_back(expect_of(rank_of(s), ctrl_sh, ex, sb, sd));
        @(posedge i_core_clk);
        start <= 1'b0;
        @(posedge i_core_clk);
        while (busy !== 1'b0) @(posedge i_core_clk);
        repeat (3) @(posedge i_core_clk);
    endtask
    // ==========================================================
    // sequence
    initial begin
        void'($urandom(32'h5673));
        repeat (20) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        for (int a = 0; a <= 16; a += 4)
            wb(1'b0, 8'(a), 32'h0, 4'hF, 32'h0);
        wb(1'b1, sase_pkg::SASE_ADR_CTRL, 32'hFFFFFFFF, 4'hF, 32'h0);
        wb(1'b0, sase_pkg::SASE_ADR_CTRL, 32'h0, 4'hF, 32'h7);
        wb(1'b1, sase_pkg::SASE_ADR_CTRL, 32'h0, 4'hE, 32'h0);
        wb(1'b0, sase_pkg::SASE_ADR_CTRL, 32'h0, 4'hF, 32'h7);
        wb(1'b1, sase_pkg::SASE_ADR_STATE, 32'hF, 4'hF, 32'h0);
        wb(1'b0, sase_pkg::SASE_ADR_STATE, 32'h0, 4'hF, 32'h0);
        wb(1'b1, 8'h10, 32'hFF, 4'hF, 32'h0);
        wb(1'b0, 8'h10, 32'h0, 4'hF, 32'h0);
        for (int c = 0; c < 8; c++) begin
            set_ctrl(3'(c));
            for (int x = 0; x < 2; x++)
                for (int r = 0; r <= 11; r++)
                    frame((r == 0) ? 11'h000 : 11'(1 << (r - 1)), 1'(x));
        end
        // several sources at once: the lowest rank must win
        for (int i = 0; i < 60; i++) begin
            set_ctrl(3'($urandom));
            frame(11'($urandom) & 11'($urandom) & 11'($urandom), 1'($urandom));
        end
        set_ctrl(3'h1);
        frame(11'h001, 1'b0);
        err_src <= 11'h000;
        repeat (4) @(posedge i_core_clk);
        chk("held_freeze", 32'(freeze), 32'h1);
        chk("held_detail", 32'(det), 32'h3);
        wb(1'b0, sase_pkg::SASE_ADR_STATE, 32'h0, 4'hF, 32'h1);
        frame(11'h000, 1'b0);
        wb(1'b1, sase_pkg::SASE_ADR_IRQ_STAT, 32'h3, 4'hF, 32'h0);
        wb(1'b0, sase_pkg::SASE_ADR_IRQ_STAT, 32'h0, 4'hF, 32'h0);
        frame(11'h004, 1'b0);
        wb(1'b0, sase_pkg::SASE_ADR_IRQ_STAT, 32'h0, 4'hF, 32'h1);
        chk("irq_masked", 32'(irq), 32'h0);
        wb(1'b1, sase_pkg::SASE_ADR_IRQ_MASK, 32'h1, 4'hF, 32'h0);
        chk("irq_on", 32'(irq), 32'h1);
        wb(1'b1, sase_pkg::SASE_ADR_IRQ_STAT, 32'h1, 4'hF, 32'h0);
        chk("irq_clr", 32'(irq), 32'h0);
        frame(11'h000, 1'b1);
        wb(1'b0, sase_pkg::SASE_ADR_IRQ_STAT, 32'h0, 4'hF, 32'h2);
        wb(1'b1, sase_pkg::SASE_ADR_IRQ_MASK, 32'h2, 4'hF, 32'h0);
        chk("irq_exp", 32'(irq), 32'h1);
        wb(1'b1, sase_pkg::SASE_ADR_IRQ_STAT, 32'h2, 4'hF, 32'h0);
        chk("irq_exp_clr", 32'(irq), 32'h0);
        wrap_up();
    end
endmodule // sase_top_bench
`default_nettype wire
